// ---- rps_sync_fsm.sv ----
`timescale 1ns/1ps
module rps_sync_fsm
  import rps_pkg::*;
#(
  parameter logic IS_EXCHANGE = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Messages from peer
  input wire logic peer_valid_i,
  input rps_ev_t peer_msg_i,
  input wire logic [RPS_CAUSE_W-1:0] peer_cause_i,
  input wire logic peer_variant_known_i,
  // Events from management
  input wire logic mgmt_valid_i,
  output logic mgmt_ready_o,
  input rps_ev_t mgmt_event_i,
  input wire logic [RPS_CAUSE_W-1:0] mgmt_cause_i,
  // Messages to peer
  output logic tx_valid_o,
  output rps_ev_t tx_msg_o,
  output logic [RPS_CAUSE_W-1:0] tx_cause_o,
  // Indications to management
  output logic ind_valid_o,
  output rps_ev_t ind_msg_o,
  output logic [RPS_CAUSE_W-1:0] ind_cause_o,
  output logic err_valid_o,
  output rps_ev_t err_event_o,
  output logic err_from_peer_o,
  // Current state
  output rps_state_t state_o
);
  rps_state_t state_q;
  rps_state_t state_d;
  logic take;
  logic from_peer;
  rps_ev_t code;
  logic [RPS_CAUSE_W-1:0] cause;
  logic tx_v;
  rps_ev_t tx_m;
  logic [RPS_CAUSE_W-1:0] tx_c;
  logic ind_v;
  logic unexp;
  logic qv_tx_v;
  rps_ev_t qv_tx_m;
  logic [RPS_CAUSE_W-1:0] qv_tx_c;
  logic qv_ind_v;
  logic qv_unexp;
  rps_state_t cr_state;

  // Peer wins a tie; management waits for every cycle that peer_valid_i is high
  assign mgmt_ready_o = !peer_valid_i;
  assign take = peer_valid_i || mgmt_valid_i;
  assign from_peer = peer_valid_i;
  assign code = from_peer ? peer_msg_i : mgmt_event_i;
  assign cause = from_peer ? peer_cause_i : mgmt_cause_i;
  // State in which refusals are relayed
  assign cr_state = IS_EXCHANGE ? RPS_ST_READY_BLOCKED : RPS_ST_READY;
  assign state_o = state_q;

  rps_query_fsm u_query (
    .state_i(state_q),
    .from_peer_i(from_peer),
    .code_i(code),
    .cause_i(cause),
    .tx_valid_o(qv_tx_v),
    .tx_msg_o(qv_tx_m),
    .tx_cause_o(qv_tx_c),
    .ind_valid_o(qv_ind_v),
    .unexp_o(qv_unexp)
  );

  always_comb begin
    state_d = state_q;
    tx_v = 1'b0;
    tx_m = code;
    tx_c = cause;
    ind_v = 1'b0;
    unexp = 1'b0;
    if (!take) begin
      unexp = 1'b0;
    end else if (rps_is_query(code)) begin
      tx_v = qv_tx_v;
      tx_m = qv_tx_m;
      tx_c = qv_tx_c;
      ind_v = qv_ind_v;
      unexp = qv_unexp;
    end else if (from_peer) begin
      case (code)
        RPS_EV_SWITCHOVER: begin
          // Unknown variant refused in any state
          if (!peer_variant_known_i) begin
            tx_v = 1'b1;
            tx_m = RPS_EV_CANNOT_REPROV;
            tx_c = RPS_CAUSE_UNKNOWN;
          end else if (state_q == RPS_ST_IN_PROGRESS) begin
            tx_v = 1'b1;
            tx_m = RPS_EV_CANNOT_REPROV;
            tx_c = RPS_CAUSE_IN_PROGRESS;
          end else if (state_q == RPS_ST_READY) begin
            ind_v = 1'b1;
          end else begin
            unexp = 1'b1;
          end
        end
        // Blocking relayed on access side only
        RPS_EV_BLOCKING: begin
          ind_v = !IS_EXCHANGE && state_q == RPS_ST_READY;
          unexp = !ind_v;
        end
        // Peer start moves exchange to busy
        RPS_EV_REPROV_STARTED: begin
          if (IS_EXCHANGE && state_q == RPS_ST_READY_BLOCKED) begin
            ind_v = 1'b1;
            state_d = RPS_ST_IN_PROGRESS;
          end else begin
            unexp = 1'b1;
          end
        end
        RPS_EV_CANNOT_REPROV: begin
          if (state_q == cr_state) begin
            ind_v = 1'b1;
          end else if (!IS_EXCHANGE && state_q == RPS_ST_IN_PROGRESS) begin
            unexp = 1'b1;
          end
        end
        default: begin
          unexp = 1'b1;
        end
      endcase
    end else begin
      case (code)
        RPS_EV_SWITCHOVER: begin
          if (state_q == RPS_ST_READY || (IS_EXCHANGE && state_q == RPS_ST_READY_BLOCKED)) begin
            tx_v = 1'b1;
          end else if (state_q == RPS_ST_NORMAL) begin
            unexp = 1'b1;
          end
        end
        RPS_EV_BLOCKING: begin
          tx_v = IS_EXCHANGE && state_q == RPS_ST_READY;
          unexp = !tx_v;
        end
        RPS_EV_REPROV_STARTED: begin
          if (!IS_EXCHANGE && state_q == RPS_ST_READY) begin
            tx_v = 1'b1;
            state_d = RPS_ST_IN_PROGRESS;
          end else if (IS_EXCHANGE && state_q == RPS_ST_READY_BLOCKED) begin
            tx_v = 1'b1;
            tx_m = RPS_EV_SWITCHOVER;
          end else begin
            unexp = 1'b1;
          end
        end
        RPS_EV_CANNOT_REPROV: begin
          tx_v = (state_q == cr_state);
          unexp = !tx_v;
        end
        RPS_EV_COMPLETED: begin
          if (state_q == RPS_ST_IN_PROGRESS) begin
            state_d = RPS_ST_NORMAL;
          end else if (!IS_EXCHANGE || state_q == RPS_ST_READY_BLOCKED) begin
            unexp = 1'b1;
          end
        end
        RPS_EV_DATA_AVAIL: begin
          if (state_q == RPS_ST_NORMAL) begin
            state_d = RPS_ST_READY;
          end else if (state_q != RPS_ST_IN_PROGRESS) begin
            unexp = 1'b1;
          end
        end
        RPS_EV_REMOVE: begin
          if (state_q == RPS_ST_READY || state_q == RPS_ST_READY_BLOCKED) begin
            state_d = RPS_ST_NORMAL;
          end else if (state_q == RPS_ST_IN_PROGRESS) begin
            unexp = 1'b1;
          end
        end
        RPS_EV_PORTS_BLOCKED: begin
          if (IS_EXCHANGE && state_q == RPS_ST_READY) begin
            tx_v = 1'b1;
            tx_m = RPS_EV_SWITCHOVER;
            state_d = RPS_ST_READY_BLOCKED;
          end else begin
            unexp = 1'b1;
          end
        end
        RPS_EV_PORTS_UNBLOCKED: begin
          if (!IS_EXCHANGE || state_q == RPS_ST_IN_PROGRESS) begin
            unexp = 1'b1;
          end else if (state_q == RPS_ST_READY_BLOCKED) begin
            state_d = RPS_ST_NORMAL;
          end
        end
        default: begin
          unexp = 1'b1;
        end
      endcase
    end
  end

  // State register; unexpected never moves it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= RPS_ST_NORMAL;
    end else if (!unexp) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_msg_o <= RPS_EV_SWITCHOVER;
      tx_cause_o <= '0;
    end else begin
      tx_valid_o <= tx_v;
      tx_msg_o <= tx_m;
      tx_cause_o <= tx_c;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ind_valid_o <= 1'b0;
      ind_msg_o <= RPS_EV_SWITCHOVER;
      ind_cause_o <= '0;
    end else begin
      ind_valid_o <= ind_v;
      ind_msg_o <= code;
      ind_cause_o <= cause;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      err_valid_o <= 1'b0;
      err_event_o <= RPS_EV_SWITCHOVER;
      err_from_peer_o <= 1'b0;
    end else begin
      err_valid_o <= unexp;
      err_event_o <= code;
      err_from_peer_o <= from_peer;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_peer(rps_ev_t e);
    peer_valid_i && peer_msg_i == e;
  endsequence
  sequence s_mgmt(rps_ev_t e);
    mgmt_valid_i && !peer_valid_i && mgmt_event_i == e;
  endsequence
  sequence s_sent(rps_ev_t e);
    tx_valid_o && tx_msg_o == e;
  endsequence

  a_unknown_variant: assert property (
    s_peer(RPS_EV_SWITCHOVER) ##0 !peer_variant_known_i |=>
      s_sent(RPS_EV_CANNOT_REPROV) ##0 tx_cause_o == RPS_CAUSE_UNKNOWN ##0 $stable(state_q))
    else $error("unknown variant not refused");
  a_query_no_move: assert property (
    peer_valid_i && rps_is_query(peer_msg_i) |=> $stable(state_q))
    else $error("query event moved state");
  a_unexp_hold: assert property (
    err_valid_o |-> $stable(state_q))
    else $error("state moved on unexpected event");
  a_data_ready: assert property (
    state_q == RPS_ST_NORMAL ##0 s_mgmt(RPS_EV_DATA_AVAIL) |=>
      state_q == RPS_ST_READY && !err_valid_o)
    else $error("data available did not reach ready");
  a_done_normal: assert property (
    state_q == RPS_ST_IN_PROGRESS ##0 s_mgmt(RPS_EV_COMPLETED) |=> state_q == RPS_ST_NORMAL)
    else $error("completion did not return to normal");
  a_access_start: assert property (
    !IS_EXCHANGE && state_q == RPS_ST_READY ##0 s_mgmt(RPS_EV_REPROV_STARTED) |=>
      s_sent(RPS_EV_REPROV_STARTED) ##0 state_q == RPS_ST_IN_PROGRESS)
    else $error("access start not sent");
  a_ports_blocked: assert property (
    IS_EXCHANGE && state_q == RPS_ST_READY ##0 s_mgmt(RPS_EV_PORTS_BLOCKED) |=>
      s_sent(RPS_EV_SWITCHOVER) ##0 state_q == RPS_ST_READY_BLOCKED)
    else $error("ports blocked step wrong");
  a_verify_normal: assert property (
    state_q == RPS_ST_NORMAL ##0 s_peer(RPS_EV_VERIFY) |=>
      s_sent(RPS_EV_NOT_READY) ##0 tx_cause_o == RPS_CAUSE_UNKNOWN ##0 ind_valid_o)
    else $error("verify in normal not refused");
  a_busy_refuse: assert property (
    state_q == RPS_ST_IN_PROGRESS ##0 s_peer(RPS_EV_SWITCHOVER) ##0 peer_variant_known_i |=>
      s_sent(RPS_EV_CANNOT_REPROV) ##0 tx_cause_o == RPS_CAUSE_IN_PROGRESS)
    else $error("busy switch-over not refused");

endmodule : rps_sync_fsm

// ---- rps_pkg.sv ----
// How it works
// - Query machine never moves; mirrors switch-over state.
// - Unknown variant switch-over: refuse, cause unknown.
// - Access switch-over: ready indicates, busy refuses.
// - Access ready: send switch-over or refusal.
// - Access completion returns busy to normal.
// - Access data available: normal becomes ready.
// - Access remove variant: ready back to normal.
// - Exchange switch-over: ports-up indicates, busy refuses.
// - Exchange blocking command sends blocking message.
// - Exchange ports blocked: send switch-over, advance.
// - Exchange blocked: start or switch-over sends switch-over.
// - Exchange peer reprov start: indicate, go busy.
// - Exchange data available and completion moves.
// - Exchange remove variant: both ready to normal.
// - Exchange ports unblocked: blocked back to normal.
// - Exchange blocked: refusals relayed both ways.
// - Variant query sent and answered unless busy.
// - Verify sent unless busy; received always indicated.
// - Ready only from ready; not-ready always.
// - Unexpected events raise error, keep state.
// - Access machine: normal, ready, in progress.
// - Exchange machine: four states incl. ports blocked.
// - Verify in normal or busy: not-ready reply.
package rps_pkg;

  localparam int unsigned RPS_CAUSE_W = 8;
  localparam logic [RPS_CAUSE_W-1:0] RPS_CAUSE_UNKNOWN = 8'h01;
  localparam logic [RPS_CAUSE_W-1:0] RPS_CAUSE_IN_PROGRESS = 8'h02;

  // Messages and internal events share one code space
  typedef enum logic [3:0] {
    RPS_EV_SWITCHOVER,
    RPS_EV_BLOCKING,
    RPS_EV_REPROV_STARTED,
    RPS_EV_CANNOT_REPROV,
    RPS_EV_VARIANT_QUERY,
    RPS_EV_VARIANT_REPLY,
    RPS_EV_VERIFY,
    RPS_EV_READY,
    RPS_EV_NOT_READY,
    RPS_EV_COMPLETED,
    RPS_EV_DATA_AVAIL,
    RPS_EV_REMOVE,
    RPS_EV_PORTS_BLOCKED,
    RPS_EV_PORTS_UNBLOCKED
  } rps_ev_t;

  // Access side never uses the ports-blocked state
  typedef enum logic [1:0] {
    RPS_ST_NORMAL,
    RPS_ST_READY,
    RPS_ST_READY_BLOCKED,
    RPS_ST_IN_PROGRESS
  } rps_state_t;

  function automatic logic rps_is_query(input rps_ev_t e);
    rps_is_query = (e == RPS_EV_VARIANT_QUERY) || (e == RPS_EV_VARIANT_REPLY) ||
                   (e == RPS_EV_VERIFY) || (e == RPS_EV_READY) ||
                   (e == RPS_EV_NOT_READY);
  endfunction : rps_is_query

endpackage : rps_pkg

// ---- rps_query_fsm.sv ----
`timescale 1ns/1ps
module rps_query_fsm
  import rps_pkg::*;
(
  // Switch-over state and current event
  input rps_state_t state_i,
  input wire logic from_peer_i,
  input rps_ev_t code_i,
  input wire logic [RPS_CAUSE_W-1:0] cause_i,
  // Message to peer
  output logic tx_valid_o,
  output rps_ev_t tx_msg_o,
  output logic [RPS_CAUSE_W-1:0] tx_cause_o,
  // Indication to management
  output logic ind_valid_o,
  output logic unexp_o
);
  logic busy;
  logic ready;

  // No own register: state is the switch-over state
  assign busy = (state_i == RPS_ST_IN_PROGRESS);
  assign ready = (state_i == RPS_ST_READY) || (state_i == RPS_ST_READY_BLOCKED);

  always_comb begin
    tx_valid_o = 1'b0;
    tx_msg_o = code_i;
    tx_cause_o = cause_i;
    ind_valid_o = 1'b0;
    unexp_o = 1'b0;
    case (code_i)
      RPS_EV_VARIANT_QUERY: begin
        if (!from_peer_i && busy) begin
          unexp_o = 1'b1;
        end else if (!busy) begin
          tx_valid_o = 1'b1;
          tx_msg_o = from_peer_i ? RPS_EV_VARIANT_REPLY : RPS_EV_VARIANT_QUERY;
        end
      end
      RPS_EV_VARIANT_REPLY: begin
        if (!from_peer_i) begin
          unexp_o = 1'b1;
        end else if (!busy) begin
          ind_valid_o = 1'b1;
        end
      end
      RPS_EV_VERIFY: begin
        if (from_peer_i) begin
          ind_valid_o = 1'b1;
          if (busy || state_i == RPS_ST_NORMAL) begin
            tx_valid_o = 1'b1;
            tx_msg_o = RPS_EV_NOT_READY;
            tx_cause_o = busy ? RPS_CAUSE_IN_PROGRESS : RPS_CAUSE_UNKNOWN;
          end
        end else if (busy) begin
          unexp_o = 1'b1;
        end else begin
          tx_valid_o = 1'b1;
        end
      end
      RPS_EV_READY: begin
        if (from_peer_i) begin
          ind_valid_o = !busy;
          unexp_o = busy;
        end else begin
          tx_valid_o = ready;
          unexp_o = !ready;
        end
      end
      RPS_EV_NOT_READY: begin
        if (from_peer_i) begin
          ind_valid_o = !busy;
        end else begin
          tx_valid_o = 1'b1;
        end
      end
      default: begin
        unexp_o = 1'b0;
      end
    endcase
  end

endmodule : rps_query_fsm

// ---- rps_peer_model.sv ----
`timescale 1ns/1ps
module rps_peer_model
  import rps_pkg::*;
(
  // Peer message lines
  output logic peer_valid_o,
  output rps_ev_t peer_msg_o,
  output logic [RPS_CAUSE_W-1:0] peer_cause_o,
  output logic peer_variant_known_o
);
  initial begin
    peer_valid_o = 1'h0;
    peer_msg_o = RPS_EV_SWITCHOVER;
    peer_cause_o = 8'h00;
    peer_variant_known_o = 1'h0;
  end

  task automatic send(input logic v, input rps_ev_t m, input logic [7:0] c, input logic k);
    peer_valid_o = v;
    // Idle lines invert so a stale code never looks current
    peer_msg_o = v ? m : rps_ev_t'(~peer_msg_o);
    peer_cause_o = v ? c : ~peer_cause_o;
    peer_variant_known_o = v ? k : ~peer_variant_known_o;
  endtask : send
endmodule : rps_peer_model

// ---- reprovision_sync_fsm_tb_top.sv ----
`timescale 1ns/1ps
module reprovision_sync_fsm_tb_top;
  import rps_pkg::*;

  typedef struct packed {
    logic tv;
    rps_ev_t tm;
    logic [7:0] tc;
    logic iv;
    logic ev;
    logic [7:0] ic;
    logic p;
    rps_ev_t e;
    rps_state_t st;
  } rps_exp_t;

  logic sys_clk_i;
  logic rst_n_i;
  logic peer_valid;
  rps_ev_t peer_msg;
  logic [7:0] peer_cause;
  logic peer_known;
  logic mgmt_valid;
  rps_ev_t mgmt_event;
  logic [7:0] mgmt_cause;
  logic tx_v [2];
  rps_ev_t tx_m [2];
  logic [7:0] tx_c [2];
  logic iv [2];
  rps_ev_t im [2];
  logic [7:0] ic [2];
  logic ev [2];
  rps_ev_t em [2];
  logic ep [2];
  rps_state_t st [2];
  logic rdy [2];
  rps_state_t ms [2];
  rps_exp_t ex [2];
  int n_mismatch;
  int n_compared;
  integer seed;
  logic [31:0] r;
  rps_ev_t code;
  logic [7:0] pc;
  logic known, pv, mv, pend;

  rps_peer_model peer (
    .peer_valid_o(peer_valid),
    .peer_msg_o(peer_msg),
    .peer_cause_o(peer_cause),
    .peer_variant_known_o(peer_known)
  );

  // Index 1 is the exchange side, index 0 the access side
  for (genvar g = 0; g < 2; g++) begin : side
    rps_sync_fsm #(.IS_EXCHANGE(1'(g))) dut (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .peer_valid_i(peer_valid),
      .peer_msg_i(peer_msg),
      .peer_cause_i(peer_cause),
      .peer_variant_known_i(peer_known),
      .mgmt_valid_i(mgmt_valid),
      .mgmt_ready_o(rdy[g]),
      .mgmt_event_i(mgmt_event),
      .mgmt_cause_i(mgmt_cause),
      .tx_valid_o(tx_v[g]),
      .tx_msg_o(tx_m[g]),
      .tx_cause_o(tx_c[g]),
      .ind_valid_o(iv[g]),
      .ind_msg_o(im[g]),
      .ind_cause_o(ic[g]),
      .err_valid_o(ev[g]),
      .err_event_o(em[g]),
      .err_from_peer_o(ep[g]),
      .state_o(st[g])
    );
  end

  initial begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic rps_exp_t snd(input rps_exp_t q, input rps_ev_t m, input logic [7:0] c);
    snd = q;
    snd.tv = 1'h1;
    snd.tm = m;
    snd.tc = c;
  endfunction : snd

  function automatic rps_exp_t model(input logic x, input rps_state_t s, input logic a,
      input logic p, input rps_ev_t e, input logic k, input logic [7:0] c);
    rps_exp_t q;
    logic nrm, rd, blk, bsy;
    q = '0;
    q.st = s;
    q.e = e;
    q.p = p;
    q.ic = c;
    nrm = (s == RPS_ST_NORMAL);
    rd = (s == RPS_ST_READY);
    blk = (s == RPS_ST_READY_BLOCKED);
    bsy = (s == RPS_ST_IN_PROGRESS);
    if (a) begin
      case (e)
        RPS_EV_VARIANT_QUERY: if (bsy) q.ev = !p;
          else q = snd(q, p ? RPS_EV_VARIANT_REPLY : RPS_EV_VARIANT_QUERY, 8'h00);
        RPS_EV_VARIANT_REPLY: if (!p) q.ev = 1'h1; else q.iv = !bsy;
        RPS_EV_VERIFY: if (!p) begin
          if (bsy) q.ev = 1'h1; else q = snd(q, RPS_EV_VERIFY, 8'h00);
        end else begin
          q.iv = 1'h1;
          if (nrm || bsy)
            q = snd(q, RPS_EV_NOT_READY, bsy ? RPS_CAUSE_IN_PROGRESS : RPS_CAUSE_UNKNOWN);
        end
        RPS_EV_READY: if (p) begin
          q.ev = bsy;
          q.iv = !bsy;
        end else if (rd || blk) q = snd(q, RPS_EV_READY, 8'h00);
          else q.ev = 1'h1;
        RPS_EV_NOT_READY: if (p) q.iv = !bsy; else q = snd(q, RPS_EV_NOT_READY, c);
        RPS_EV_SWITCHOVER: if (p && !k) q = snd(q, RPS_EV_CANNOT_REPROV, RPS_CAUSE_UNKNOWN);
          else if (p) begin
            if (rd) q.iv = 1'h1;
            else if (bsy) q = snd(q, RPS_EV_CANNOT_REPROV, RPS_CAUSE_IN_PROGRESS);
            else q.ev = 1'h1;
          end else if (rd || blk) q = snd(q, RPS_EV_SWITCHOVER, 8'h00);
          else q.ev = nrm;
        // Blocking started; local blocking is exchange only
        RPS_EV_BLOCKING: if (x) begin
          if (!p && rd) q = snd(q, RPS_EV_BLOCKING, 8'h00); else q.ev = 1'h1;
        end else if (p && rd) q.iv = 1'h1;
          else q.ev = 1'h1;
        RPS_EV_REPROV_STARTED: if (x && p && blk) begin
          q.iv = 1'h1;
          q.st = RPS_ST_IN_PROGRESS;
        end else if (x && !p && blk) q = snd(q, RPS_EV_SWITCHOVER, 8'h00);
          else if (!x && !p && rd) begin
            q = snd(q, RPS_EV_REPROV_STARTED, 8'h00);
            q.st = RPS_ST_IN_PROGRESS;
          end else q.ev = 1'h1;
        RPS_EV_CANNOT_REPROV: if (p) begin
          if (x ? blk : rd) q.iv = 1'h1; else q.ev = !x && bsy;
        end else if (x ? blk : rd) q = snd(q, RPS_EV_CANNOT_REPROV, c);
          else q.ev = 1'h1;
        RPS_EV_COMPLETED: if (p) q.ev = 1'h1;
          else if (bsy) q.st = RPS_ST_NORMAL;
          else q.ev = !x || blk;
        RPS_EV_DATA_AVAIL: if (p) q.ev = 1'h1;
          else if (nrm) q.st = RPS_ST_READY;
          else q.ev = !bsy;
        RPS_EV_REMOVE: if (p) q.ev = 1'h1;
          else if (rd || blk) q.st = RPS_ST_NORMAL;
          else q.ev = bsy;
        RPS_EV_PORTS_BLOCKED: if (p || !x || !rd) q.ev = 1'h1;
          else begin
            q = snd(q, RPS_EV_SWITCHOVER, 8'h00);
            q.st = RPS_ST_READY_BLOCKED;
          end
        default: if (p || !x) q.ev = 1'h1;
          else if (blk) q.st = RPS_ST_NORMAL;
          else q.ev = bsy;
      endcase
    end
    model = q;
  endfunction : model

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %0h want %0h", $time, seen, want);
    end
  endtask : chk

  task automatic check_side(input int s);
    chk(8'(st[s]), 8'(ex[s].st));
    chk(8'(rdy[s]), 8'(!peer_valid));
    chk(8'(tx_v[s]), 8'(ex[s].tv));
    chk(8'(iv[s]), 8'(ex[s].iv));
    chk(8'(ev[s]), 8'(ex[s].ev));
    if (ex[s].tv) chk(8'(tx_m[s]), 8'(ex[s].tm));
    if (ex[s].tv && ex[s].tm inside {RPS_EV_CANNOT_REPROV, RPS_EV_NOT_READY})
      chk(tx_c[s], ex[s].tc);
    if (ex[s].iv) chk(8'(im[s]), 8'(ex[s].e));
    if (ex[s].iv) chk(ic[s], ex[s].ic);
    if (ex[s].ev) chk(8'(em[s]), 8'(ex[s].e));
    if (ex[s].ev) chk(8'(ep[s]), 8'(ex[s].p));
  endtask : check_side

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Run needs about 4000 cycles
  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  initial begin
    seed = 32'h4A26;
    n_mismatch = 0;
    n_compared = 0;
    rst_n_i = 1'h0;
    mgmt_valid = 1'h0;
    mgmt_event = RPS_EV_SWITCHOVER;
    mgmt_cause = 8'h00;
    pend = 1'h0;
    for (int s = 0; s < 2; s++) begin
      ms[s] = RPS_ST_NORMAL;
      ex[s] = model(1'(s), RPS_ST_NORMAL, 1'h0, 1'h0, RPS_EV_SWITCHOVER, 1'h0, 8'h00);
    end
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    for (int i = 0; i < 4000; i++) begin
      @(negedge sys_clk_i);
      for (int s = 0; s < 2; s++) check_side(s);
      r = $random(seed);
      code = rps_ev_t'(4'({$random(seed)} % 14));
      pc = 8'($random(seed));
      known = r[5] | r[6];
      // Second reset in mid-run
      rst_n_i = (i != 2000) ? 1'h1 : 1'h0;
      if (!pend) begin
        mgmt_event = rps_ev_t'(4'({$random(seed)} % 14));
        mgmt_cause = 8'($random(seed));
      end
      // Collisions leave the management event held for one more cycle
      mv = rst_n_i && (pend || r[1:0] >= 2'h2);
      pv = rst_n_i && !pend && (r[1:0] == 2'h1 || (r[1:0] == 2'h3 && r[4]));
      peer.send(pv, code, pc, known);
      mgmt_valid = mv;
      for (int s = 0; s < 2; s++) begin
        if (!rst_n_i) ms[s] = RPS_ST_NORMAL;
        ex[s] = model(1'(s), ms[s], pv || mv, pv, pv ? code : mgmt_event, known,
                      pv ? pc : mgmt_cause);
        ms[s] = ex[s].st;
      end
      pend = pv && mv;
    end
    // Last event's answer still to be looked at
    @(negedge sys_clk_i);
    for (int s = 0; s < 2; s++) check_side(s);
    results();
  end
endmodule : reprovision_sync_fsm_tb_top
